// ==== design/rcf_pkg.sv ====
// Constants, codes and state type of the reset-cause flag logic
package rcf_pkg;

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [7:0] OFS_FLAGS    = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_PINSEL   = 8'h08;
  localparam logic [7:0] OFS_VSEL     = 8'h0c;
  localparam logic [7:0] OFS_IRQ_ST   = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_WDT_KICK = 8'h18;

  localparam int FLAG_CTRL = 3;
  localparam int FLAG_LOW  = 2;
  localparam int FLAG_VSEL = 1;
  localparam int FLAG_WCFG = 0;
  localparam int ST_TO     = 0;
  localparam int ST_PD     = 1;
  localparam int ST_SLEEP  = 2;

  localparam logic [3:0] FLAGS_POR = 4'h0;
  localparam logic [3:0] IRQ_POR   = 4'h0;

  // ****************************************
  // Select codes
  // ****************************************
  localparam logic [7:0] PINSEL_IO  = 8'h55;
  localparam logic [7:0] PINSEL_PIN = 8'haa;
  localparam logic [7:0] PINSEL_POR = 8'h55;
  localparam logic [7:0] VSEL_A     = 8'h55;
  localparam logic [7:0] VSEL_B     = 8'h33;
  localparam logic [7:0] VSEL_C     = 8'h99;
  localparam logic [7:0] VSEL_D     = 8'haa;
  localparam logic [7:0] VSEL_POR   = 8'h55;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS       = 25;
  localparam int SRESET_NS    = 500;
  localparam int LVR_QUAL_NS  = 1000;
  localparam int SRESET_CYCLES = (SRESET_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] SRESET_LOAD = 8'(SRESET_CYCLES - 1);
  localparam logic [7:0] LVR_QUAL_CYCLES = 8'((LVR_QUAL_NS + CLK_NS - 1) / CLK_NS);
  localparam int TB_LIMIT  = 16;
  localparam int WDT_LIMIT = 256;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_DELAY = 3'b010,
    ST_APPLY = 3'b100
  } rcf_state_type;

endpackage

// ==== design/rcf_sync.sv ====
// Two-stage synchroniser for an input from outside the clock domain
`timescale 1ns/1ps
module rcf_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      sync_out
);
  logic stage1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// ==== design/rcf_counter.sv ====
// Wrapping counter with clear and enable, pulses when it wraps
`timescale 1ns/1ps
module rcf_counter #(
  parameter int LIMIT = 16,
  parameter int W     = 8
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clear,
  input  wire logic enable,
  output logic      hit
);
  localparam logic [W-1:0] LAST = W'(LIMIT - 1);
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic         next_hit;

  always_comb begin
    next_count = count;
    next_hit   = 1'b0;
    if (clear) begin
      next_count = '0;
    end else if (enable) begin
      if (count == LAST) begin
        next_count = '0;
        next_hit   = 1'b1;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      hit   <= 1'b0;
    end else begin
      count <= next_count;
      hit   <= next_hit;
    end
  end
endmodule

// ==== design/rcf_top.sv ====
// Reset-cause flags, reset sequencing and APB register slave
`timescale 1ns/1ps
module rcf_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_reset_pin_n,
  input  wire logic        low_supply_detect,
  input  wire logic        sleep_mode,
  output logic             irq,
  output logic             core_reset,
  output logic             pc_clear,
  output logic             sp_clear,
  output logic             sp_top_load,
  output logic             int_disable,
  output logic             timers_off,
  output logic             port_init
);

  // ****************************************
  // Input synchronisers and counters
  // ****************************************
  logic pin_n_s;
  logic low_s;
  logic tb_tick;
  logic wdt_hit;
  logic wdt_clear;
  logic tb_clear;

  rcf_sync #(.RST_VAL(1'b1)) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (ext_reset_pin_n),
    .sync_out (pin_n_s)
  );

  rcf_sync #(.RST_VAL(1'b0)) u_low_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (low_supply_detect),
    .sync_out (low_s)
  );

  rcf_counter #(.LIMIT(rcf_pkg::TB_LIMIT), .W(8)) u_time_base (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (tb_clear),
    .enable  (1'b1),
    .hit     (tb_tick)
  );

  rcf_counter #(.LIMIT(rcf_pkg::WDT_LIMIT), .W(8)) u_watchdog (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (wdt_clear),
    .enable  (tb_tick),
    .hit     (wdt_hit)
  );

  // ****************************************
  // State
  // ****************************************
  rcf_pkg::rcf_state_type state, next_state;
  logic [7:0]  dly_cnt, next_dly_cnt;
  logic [7:0]  qual_cnt, next_qual_cnt;
  logic [3:0]  reset_cause_flags, next_flags;
  logic        to_flag, next_to;
  logic        pd_flag, next_pd;
  logic [7:0]  reset_pin_select, next_pinsel;
  logic [7:0]  low_supply_select, next_vsel;
  logic [3:0]  irq_st, next_irq_st;
  logic [3:0]  irq_mask, next_irq_mask;
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr, next_irq;
  logic        next_core_reset, next_warm, next_init;

  logic setup, wr_en, qual_met, pin_cause, wdt_run, wdt_sleep;
  logic hard_cause, bad_pinsel, bad_vsel, kick;
  logic [3:0] hw_set;

  // ****************************************
  // Cause detection
  // ****************************************
  always_comb begin
    setup      = psel & ~penable;
    wr_en      = psel & penable & pready & pwrite;
    kick       = wr_en & (paddr == rcf_pkg::OFS_WDT_KICK);
    // Detector is off in power-down, so sleep holds the qualifier at zero
    qual_met   = (qual_cnt == rcf_pkg::LVR_QUAL_CYCLES);
    pin_cause  = (reset_pin_select == rcf_pkg::PINSEL_PIN) & ~pin_n_s;
    wdt_run    = wdt_hit & ~sleep_mode;
    wdt_sleep  = wdt_hit & sleep_mode;
    hard_cause = pin_cause | qual_met | wdt_run;
    bad_pinsel = (reset_pin_select != rcf_pkg::PINSEL_IO) &
                 (reset_pin_select != rcf_pkg::PINSEL_PIN);
    bad_vsel   = (low_supply_select != rcf_pkg::VSEL_A) &
                 (low_supply_select != rcf_pkg::VSEL_B) &
                 (low_supply_select != rcf_pkg::VSEL_C) &
                 (low_supply_select != rcf_pkg::VSEL_D);
    next_qual_cnt = 8'h00;
    if (low_s && !sleep_mode) begin
      next_qual_cnt = qual_met ? qual_cnt : qual_cnt + 8'h01;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    next_state   = state;
    next_dly_cnt = dly_cnt;
    hw_set       = 4'h0;
    hw_set[rcf_pkg::FLAG_LOW] = qual_met;
    unique case (state)
      rcf_pkg::ST_RUN: begin
        if (hard_cause) begin
          next_state = rcf_pkg::ST_APPLY;
        end else if (bad_pinsel || bad_vsel) begin
          next_state   = rcf_pkg::ST_DELAY;
          next_dly_cnt = rcf_pkg::SRESET_LOAD;
        end
        // Both flags may set together when both codes are bad
        hw_set[rcf_pkg::FLAG_CTRL] = ~hard_cause & bad_pinsel;
        hw_set[rcf_pkg::FLAG_VSEL] = ~hard_cause & bad_vsel;
      end
      rcf_pkg::ST_DELAY: begin
        if (hard_cause || dly_cnt == 8'h00) begin
          next_state = rcf_pkg::ST_APPLY;
        end else begin
          next_dly_cnt = dly_cnt - 8'h01;
        end
      end
      rcf_pkg::ST_APPLY: begin
        // A held pin, a lasting low supply or a fresh time-out keeps the core in reset
        if (!(pin_cause || qual_met || wdt_run)) begin
          next_state = rcf_pkg::ST_RUN;
        end
      end
    endcase
    next_core_reset = (next_state == rcf_pkg::ST_APPLY);
    next_init       = next_core_reset;
    next_warm       = wdt_sleep & (state != rcf_pkg::ST_APPLY);
    wdt_clear       = (state == rcf_pkg::ST_APPLY) | next_warm | kick;
    tb_clear        = (state == rcf_pkg::ST_APPLY);
  end

  // ****************************************
  // Registers and APB slave
  // ****************************************
  always_comb begin
    next_flags    = reset_cause_flags;
    next_to       = to_flag;
    next_pd       = pd_flag;
    next_pinsel   = reset_pin_select;
    next_vsel     = low_supply_select;
    next_irq_mask = irq_mask;
    next_irq_st   = irq_st;
    if (wr_en) begin
      unique case (paddr)
        rcf_pkg::OFS_FLAGS:    next_flags    = pwdata[3:0];
        rcf_pkg::OFS_STATUS: begin
          next_to = to_flag & pwdata[rcf_pkg::ST_TO];
          next_pd = pd_flag & pwdata[rcf_pkg::ST_PD];
        end
        rcf_pkg::OFS_PINSEL:   next_pinsel   = pwdata[7:0];
        rcf_pkg::OFS_VSEL:     next_vsel     = pwdata[7:0];
        rcf_pkg::OFS_IRQ_ST:   next_irq_st   = irq_st & ~pwdata[3:0];
        rcf_pkg::OFS_IRQ_MASK: next_irq_mask = pwdata[3:0];
        default: begin
        end
      endcase
    end
    // Hardware sets win over a clear in the same cycle
    next_flags  = next_flags | hw_set;
    next_irq_st = next_irq_st | {hw_set[3:1], wdt_hit};
    // Pin and low-supply resets leave both status flags alone
    if (wdt_hit) begin
      next_to = 1'b1;
    end
    if (wdt_sleep) begin
      next_pd = 1'b1;
    end
    if (state == rcf_pkg::ST_APPLY) begin
      // Restored only on leaving, otherwise a held pin would cut its own reset short
      if (next_state == rcf_pkg::ST_RUN) begin
        next_pinsel = rcf_pkg::PINSEL_POR;
      end
      if (bad_vsel) begin
        next_vsel = rcf_pkg::VSEL_POR;
      end
    end
    next_irq     = |(next_irq_st & next_irq_mask);
    next_pready  = setup;
    next_pslverr = 1'b0;
    next_prdata  = 32'h0000_0000;
    if (setup && !pwrite) begin
      unique case (paddr)
        rcf_pkg::OFS_FLAGS:    next_prdata = {28'h0, reset_cause_flags};
        rcf_pkg::OFS_STATUS:   next_prdata = {29'h0, sleep_mode, pd_flag, to_flag};
        rcf_pkg::OFS_PINSEL:   next_prdata = {24'h0, reset_pin_select};
        rcf_pkg::OFS_VSEL:     next_prdata = {24'h0, low_supply_select};
        rcf_pkg::OFS_IRQ_ST:   next_prdata = {28'h0, irq_st};
        rcf_pkg::OFS_IRQ_MASK: next_prdata = {28'h0, irq_mask};
        rcf_pkg::OFS_WDT_KICK: next_prdata = 32'h0000_0000;
        default:               next_pslverr = 1'b1;
      endcase
    end else if (setup) begin
      next_pslverr = (paddr > rcf_pkg::OFS_WDT_KICK) | (paddr[1:0] != 2'h0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state             <= rcf_pkg::ST_RUN;
      dly_cnt           <= 8'h00;
      qual_cnt          <= 8'h00;
      reset_cause_flags <= rcf_pkg::FLAGS_POR;
      to_flag           <= 1'b0;
      pd_flag           <= 1'b0;
      reset_pin_select  <= rcf_pkg::PINSEL_POR;
      low_supply_select <= rcf_pkg::VSEL_POR;
      irq_st            <= rcf_pkg::IRQ_POR;
      irq_mask          <= rcf_pkg::IRQ_POR;
      prdata            <= 32'h0000_0000;
      pready            <= 1'b0;
      pslverr           <= 1'b0;
      irq               <= 1'b0;
      core_reset        <= 1'b1;
      pc_clear          <= 1'b1;
      sp_clear          <= 1'b0;
      sp_top_load       <= 1'b1;
      int_disable       <= 1'b1;
      timers_off        <= 1'b1;
      port_init         <= 1'b1;
    end else begin
      state             <= next_state;
      dly_cnt           <= next_dly_cnt;
      qual_cnt          <= next_qual_cnt;
      reset_cause_flags <= next_flags;
      to_flag           <= next_to;
      pd_flag           <= next_pd;
      reset_pin_select  <= next_pinsel;
      low_supply_select <= next_vsel;
      irq_st            <= next_irq_st;
      irq_mask          <= next_irq_mask;
      prdata            <= next_prdata;
      pready            <= next_pready;
      pslverr           <= next_pslverr;
      irq               <= next_irq;
      core_reset        <= next_core_reset;
      pc_clear          <= next_init | next_warm;
      sp_clear          <= next_warm;
      sp_top_load       <= next_init;
      int_disable       <= next_init;
      timers_off        <= next_init;
      port_init         <= next_init;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  localparam int SRES_DLY = rcf_pkg::SRESET_CYCLES + 1;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  unimpl_zero_a: assert property (setup && !pwrite && paddr == rcf_pkg::OFS_FLAGS
    |=> prdata[31:4] == 28'h0) else $error("flag upper bits not zero");
  low_flag_a: assert property (qual_met |=> reset_cause_flags[rcf_pkg::FLAG_LOW] && core_reset)
    else $error("low supply flag not set");
  vsel_flag_a: assert property (state == rcf_pkg::ST_RUN && bad_vsel && !hard_cause
    |=> reset_cause_flags[rcf_pkg::FLAG_VSEL]) else $error("vsel flag not set");
  wdt_run_a: assert property (wdt_run |=> core_reset && to_flag)
    else $error("running time-out did not reset");
  wdt_sleep_a: assert property (wdt_sleep && state != rcf_pkg::ST_APPLY
    |=> pc_clear && sp_clear && to_flag && pd_flag && !core_reset)
    else $error("sleeping time-out wrong");
  pin_keeps_a: assert property (pin_cause && !wdt_hit && !wr_en
    |=> $stable(to_flag) && $stable(pd_flag)) else $error("status changed by pin");
  wdt_pd_keep_a: assert property (wdt_run && !wr_en |=> pd_flag == $past(pd_flag))
    else $error("power-down flag changed");
  init_out_a: assert property (core_reset |-> int_disable && timers_off && port_init
    && sp_top_load && pc_clear) else $error("init outputs missing");
  wdt_restart_a: assert property (core_reset |=> !wdt_hit [*4])
    else $error("watchdog not cleared");
  ctrl_delay_a: assert property (state == rcf_pkg::ST_RUN && bad_pinsel && !hard_cause
    |=> reset_cause_flags[rcf_pkg::FLAG_CTRL] ##[0:SRES_DLY] core_reset)
    else $error("bad pin select not reset");
  vsel_restore_a: assert property (state == rcf_pkg::ST_APPLY && bad_vsel
    |=> low_supply_select == rcf_pkg::VSEL_POR) else $error("vsel not restored");

  cov_warm_c: cover property (wdt_sleep ##1 sp_clear);
  cov_delay_c: cover property (state == rcf_pkg::ST_DELAY ##1 state == rcf_pkg::ST_APPLY);
  cov_pin_c: cover property (pin_cause ##1 core_reset);
  cov_irq_c: cover property (!irq ##1 irq);

endmodule

// ==== tb/test_reset_cause_flag_logic.sv ====
// Self-checking bench for the reset-cause flag logic
`timescale 1ns/1ps
module test_reset_cause_flag_logic;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_reset_pin_n;
  logic        low_supply_detect;
  logic        sleep_mode;
  logic        irq;
  logic        core_reset;
  logic        pc_clear;
  logic        sp_clear;
  logic        sp_top_load;
  logic        int_disable;
  logic        timers_off;
  logic        port_init;
  int          failures;
  int          checks;
  int          seed;
  int          n;
  logic [31:0] d;
  logic [33:0] note;
  logic [33:0] notes[$];
  logic [7:0]  codes[4];

  rcf_top u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_reset_pin_n(ext_reset_pin_n), .low_supply_detect(low_supply_detect),
    .sleep_mode(sleep_mode), .irq(irq), .core_reset(core_reset), .pc_clear(pc_clear),
    .sp_clear(sp_clear), .sp_top_load(sp_top_load), .int_disable(int_disable),
    .timers_off(timers_off), .port_init(port_init)
  );

  // ****************************************
  // Checking and closing
  // ****************************************
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task conclude;
    if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Oldest note matches the answer now on the bus
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      note = notes.pop_front();
      check("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
      if (note[33] === 1'b0) check("prdata", prdata, note[31:0]);
    end
  end

  // ****************************************
  // Bus and reset tasks
  // ****************************************
  // Idle edge at the end keeps two transfers from touching psel in one step
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [32:0] e);
    int k;
    notes.push_back({w, e});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    check("pready", {31'h0, pready}, 32'h1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd, 33'h0);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, {1'b0, e});
  endtask

  task init_outs(input logic [31:0] e);
    check("init", {26'h0, core_reset, pc_clear, sp_top_load, int_disable, timers_off,
                   port_init}, e);
  endtask

  task power_on;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    init_outs(32'h3f);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    init_outs(32'h0);
  endtask

  // Returns the cycles until the full reset shows, then waits for its end
  task wait_rst(output int cnt);
    int m;
    cnt = 0;
    m   = 0;
    while (core_reset !== 1'b1 && cnt < 6000) begin
      @(posedge pclk);
      cnt++;
    end
    init_outs(32'h3f);
    while (core_reset !== 1'b0 && m < 200) begin
      @(posedge pclk);
      m++;
    end
    @(posedge pclk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    #(40000 * 25);
    failures++;
    conclude;
  end

  initial begin
    seed              = 98656;
    failures          = 0;
    checks            = 0;
    presetn           = 1'b0;
    psel              = 1'b0;
    penable           = 1'b0;
    pwrite            = 1'b0;
    paddr             = 8'h00;
    pwdata            = 32'h0;
    ext_reset_pin_n   = 1'b1;
    low_supply_detect = 1'b0;
    sleep_mode        = 1'b0;
    codes = '{rcf_pkg::VSEL_A, rcf_pkg::VSEL_B, rcf_pkg::VSEL_C, rcf_pkg::VSEL_D};
    power_on;
    rd(rcf_pkg::OFS_FLAGS, 32'h0);
    rd(rcf_pkg::OFS_STATUS, 32'h0);
    rd(rcf_pkg::OFS_PINSEL, 32'h55);
    rd(rcf_pkg::OFS_VSEL, 32'h55);
    d = $random(seed);
    wr(rcf_pkg::OFS_FLAGS, d);
    rd(rcf_pkg::OFS_FLAGS, {28'h0, d[3:0]});
    wr(rcf_pkg::OFS_FLAGS, 32'h0);
    rd(rcf_pkg::OFS_FLAGS, 32'h0);
    xfer(1'b0, 8'h1c, 32'h0, {1'b1, 32'h0});
    // Every defined level code is kept and causes no reset
    wr(rcf_pkg::OFS_WDT_KICK, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(rcf_pkg::OFS_VSEL, {24'h0, codes[i]});
      rd(rcf_pkg::OFS_VSEL, {24'h0, codes[i]});
    end
    check("no reset", {31'h0, core_reset}, 32'h0);
    wr(rcf_pkg::OFS_IRQ_MASK, 32'hf);
    wr(rcf_pkg::OFS_VSEL, {24'h0, ~rcf_pkg::VSEL_B});
    repeat (3) @(posedge pclk);
    check("irq", {31'h0, irq}, 32'h1);
    wait_rst(n);
    check("sreset delay", {31'h0, n >= rcf_pkg::SRESET_CYCLES - 6}, 32'h1);
    rd(rcf_pkg::OFS_FLAGS, 32'h2);
    rd(rcf_pkg::OFS_VSEL, 32'h55);
    wr(rcf_pkg::OFS_IRQ_ST, 32'hf);
    @(posedge pclk);
    check("irq clear", {31'h0, irq}, 32'h0);
    wr(rcf_pkg::OFS_FLAGS, 32'h0);
    // Bad pin select with the interrupt masked
    wr(rcf_pkg::OFS_WDT_KICK, 32'h0);
    wr(rcf_pkg::OFS_IRQ_MASK, 32'h0);
    wr(rcf_pkg::OFS_PINSEL, 32'h12);
    repeat (3) @(posedge pclk);
    check("irq masked", {31'h0, irq}, 32'h0);
    wait_rst(n);
    rd(rcf_pkg::OFS_FLAGS, 32'h8);
    rd(rcf_pkg::OFS_PINSEL, 32'h55);
    wr(rcf_pkg::OFS_IRQ_ST, 32'hf);
    wr(rcf_pkg::OFS_FLAGS, 32'h0);
    // Running watchdog: no kicks until it fires
    wait_rst(n);
    check("wdt period", {31'h0, n > 4000}, 32'h1);
    rd(rcf_pkg::OFS_STATUS, 32'h1);
    rd(rcf_pkg::OFS_FLAGS, 32'h0);
    // Pin acts only when selected as the reset input
    wr(rcf_pkg::OFS_WDT_KICK, 32'h0);
    ext_reset_pin_n <= 1'b0;
    repeat (10) @(posedge pclk);
    check("pin as io", {31'h0, core_reset}, 32'h0);
    ext_reset_pin_n <= 1'b1;
    wr(rcf_pkg::OFS_PINSEL, 32'haa);
    rd(rcf_pkg::OFS_PINSEL, 32'haa);
    ext_reset_pin_n <= 1'b0;
    repeat (10) @(posedge pclk);
    check("pin reset", {31'h0, core_reset}, 32'h1);
    ext_reset_pin_n <= 1'b1;
    repeat (5) @(posedge pclk);
    rd(rcf_pkg::OFS_STATUS, 32'h1);
    rd(rcf_pkg::OFS_PINSEL, 32'h55);
    // Short dip is ignored, long one qualifies
    wr(rcf_pkg::OFS_WDT_KICK, 32'h0);
    low_supply_detect <= 1'b1;
    repeat (20) @(posedge pclk);
    low_supply_detect <= 1'b0;
    repeat (5) @(posedge pclk);
    check("short dip", {31'h0, core_reset}, 32'h0);
    low_supply_detect <= 1'b1;
    repeat (60) @(posedge pclk);
    check("low reset", {31'h0, core_reset}, 32'h1);
    low_supply_detect <= 1'b0;
    repeat (5) @(posedge pclk);
    rd(rcf_pkg::OFS_FLAGS, 32'h4);
    rd(rcf_pkg::OFS_STATUS, 32'h1);
    wr(rcf_pkg::OFS_FLAGS, 32'h0);
    rd(rcf_pkg::OFS_FLAGS, 32'h0);
    // Watchdog while asleep gives a warm wake only
    sleep_mode <= 1'b1;
    wr(rcf_pkg::OFS_WDT_KICK, 32'h0);
    n = 0;
    while (pc_clear !== 1'b1 && n < 6000) begin
      @(posedge pclk);
      n++;
    end
    check("warm wake", {30'h0, sp_clear, core_reset}, 32'h2);
    sleep_mode <= 1'b0;
    @(posedge pclk);
    rd(rcf_pkg::OFS_STATUS, 32'h3);
    rd(rcf_pkg::OFS_IRQ_ST, 32'h5);
    wr(rcf_pkg::OFS_STATUS, 32'h1);
    rd(rcf_pkg::OFS_STATUS, 32'h1);
    power_on;
    rd(rcf_pkg::OFS_STATUS, 32'h0);
    rd(rcf_pkg::OFS_IRQ_MASK, 32'h0);
    conclude;
  end
endmodule
